// ===== evp_pkg.sv
// package of constants, types and carriers for the page eviction sequencer
package evp_pkg;

   // ------------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_RESULT = 8'h08;
   localparam logic [7:0] OFS_DESC   = 8'h0C;
   localparam logic [7:0] OFS_TGT    = 8'h10;
   localparam logic [7:0] OFS_SLOT   = 8'h14;
   localparam logic [7:0] OFS_LIN    = 8'h18;
   localparam logic [7:0] OFS_ENCL   = 8'h1C;
   localparam logic [7:0] OFS_META   = 8'h20;
   localparam logic [7:0] OFS_DEST   = 8'h24;
   localparam logic [7:0] OFS_VER    = 8'h28;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int CTRL_START  = 0;
   localparam int CTRL_MODE64 = 1;
   localparam int CTRL_CPL    = 2;
   localparam int ALIGN_DESC  = 5;
   localparam int ALIGN_PAGE  = 12;
   localparam int ALIGN_SLOT  = 3;
   localparam int ALIGN_META  = 7;
   localparam int VER_SHIFT   = 32;

   // ------------------------------------------------------------------
   // result codes and reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] RES_OK            = 32'h0000_0000;
   localparam logic [31:0] NOT_BLOCKED_CODE  = 32'h0000_0001;
   localparam logic [31:0] NOT_TRACKED_CODE  = 32'h0000_0002;
   localparam logic [31:0] CHILD_PRESENT_CODE = 32'h0000_0003;
   localparam logic [31:0] SLOT_OCCUPIED_CODE = 32'h0000_0004;
   localparam logic [63:0] EID_NONE          = 64'h0000_0000_0000_0000;

   typedef enum logic [2:0] {
      PT_REGULAR = 3'b000,
      PT_THREAD  = 3'b001,
      PT_TRIMMED = 3'b010,
      PT_ENCLAVE = 3'b011,
      PT_VERSION = 3'b100
   } evp_ptype_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_CHECK = 3'b001,
      ST_CRYPT = 3'b010,
      ST_WRITE = 3'b011,
      ST_SLOT  = 3'b100
   } evp_fsm_t;

   // page map lookups and side conditions, from same-clock logic
   typedef struct packed {
      logic        seg_fault;
      logic        noncanon;
      logic        access_fault;
      logic        tgt_in_pool;
      logic        slot_in_pool;
      logic        conc_busy;
      logic        va_changing;
      logic        track_busy;
      logic        consist_fail;
      logic        tgt_valid;
      evp_ptype_t  tgt_ptype;
      logic        slot_valid;
      evp_ptype_t  slot_ptype;
      logic        block_ok;
      logic        blocked;
      logic        track_ok;
      logic        child_present;
      logic        slot_used;
      logic [2:0]  perm;
      logic        pending;
      logic        modified;
      logic        perm_restrict_bit;
      logic [31:0] linear_addr_field;
      logic [63:0] owner_eid;
      logic [63:0] own_eid;
   } evp_map_t;

   // eviction side effects toward crypto engine, memory and page map
   typedef struct packed {
      logic        crypt_req;
      logic [31:0] hdr_lin;
      evp_ptype_t  hdr_ptype;
      logic [2:0]  hdr_perm;
      logic        hdr_pending;
      logic        hdr_modified;
      logic        hdr_pr;
      logic [63:0] hdr_eid;
      logic [63:0] counter;
      logic [31:0] dest_ptr;
      logic [31:0] meta_ptr;
      logic        meta_we;
      logic [63:0] meta_eid;
      logic        desc_we;
      logic [31:0] desc_addr;
      logic        slot_we;
      logic [31:0] slot_addr;
      logic [63:0] slot_val;
      logic        map_inv;
      logic [31:0] map_addr;
   } evp_out_t;
endpackage

// ===== evp_evict.sv
// page eviction sequencer with avalon-mm register slave
`timescale 1ns/1ps
module evp_evict
(
   // clock and reset
   input  wire logic                 MCLK,
   input  wire logic                 RST_B,
   // avalon-mm register slave
   input  wire logic [7:0]           AVS_ADDRESS,
   input  wire logic                 AVS_READ,
   input  wire logic                 AVS_WRITE,
   input  wire logic [31:0]          AVS_WRITEDATA,
   input  wire logic [3:0]           AVS_BYTEENABLE,
   output logic      [31:0]          AVS_READDATA,
   output logic                      AVS_WAITREQUEST,
   // page map and side conditions
   input  wire evp_pkg::evp_map_t    MAP_INFO,
   // crypto engine completion
   input  wire logic                 CRYPT_DONE,
   // eviction effects
   output evp_pkg::evp_out_t         EVICT_OUT
);
   import evp_pkg::*;

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      evp_fsm_t    fsm;
      logic        done;
      logic        gp;
      logic        pf;
      logic        pf_slot;
      logic [5:0]  flags;
      logic [31:0] result;
      logic        mode64;
      logic [1:0]  cpl;
      logic [31:0] desc;
      logic [31:0] tgt;
      logic [31:0] slot;
      logic [31:0] lin;
      logic [31:0] encl;
      logic [31:0] meta;
      logic [31:0] dest;
      logic [31:0] ver;
      logic        ack;
      logic [31:0] rdata;
      evp_out_t    o;
   } evp_state_t;

   // flag bit order inside flags: zf cf pf af of sf
   localparam int FL_ZF = 5;
   localparam int FL_CF = 4;

   evp_state_t st_q;
   evp_state_t st_d;
   logic [1:0] rst_sync_q;
   logic       rst_n;

   // byte-lane merge used for every writable register except OFS_CTRL, which takes only byte lane 0
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // true for page types that belong to an enclave
   function automatic logic is_child(input evp_ptype_t t);
      return (t == PT_REGULAR) || (t == PT_THREAD) || (t == PT_TRIMMED);
   endfunction

   // ------------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------------
   // assert asynchronously, release through two flops
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // ------------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------------
   // one wait cycle per access keeps read data on a flop
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~st_q.ack;
   assign AVS_READDATA    = st_q.rdata;
   assign EVICT_OUT       = st_q.o;

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   always_comb begin
      logic busy;
      logic same_pg;
      st_d = st_q;
      busy = (st_q.fsm != ST_IDLE);
      same_pg = (st_q.tgt[31:ALIGN_PAGE] == st_q.slot[31:ALIGN_PAGE]);
      // strobes last one cycle
      st_d.o.meta_we = 1'b0;
      st_d.o.desc_we = 1'b0;
      st_d.o.slot_we = 1'b0;
      st_d.o.map_inv = 1'b0;

      // bus access: capture read data, apply write on the ack cycle
      st_d.ack = (AVS_READ | AVS_WRITE) & ~st_q.ack;
      if (AVS_READ && !st_q.ack) begin
         case (AVS_ADDRESS)
            OFS_CTRL:   st_d.rdata = {28'h000_0000, st_q.cpl,
                                      st_q.mode64, 1'b0};
            OFS_STATUS: st_d.rdata = {21'h00_0000, st_q.flags, st_q.pf_slot,
                                      st_q.pf, st_q.gp, st_q.done,
                                      busy};
            OFS_RESULT: st_d.rdata = st_q.result;
            OFS_DESC:   st_d.rdata = st_q.desc;
            OFS_TGT:    st_d.rdata = st_q.tgt;
            OFS_SLOT:   st_d.rdata = st_q.slot;
            OFS_LIN:    st_d.rdata = st_q.lin;
            OFS_ENCL:   st_d.rdata = st_q.encl;
            OFS_META:   st_d.rdata = st_q.meta;
            OFS_DEST:   st_d.rdata = st_q.dest;
            OFS_VER:    st_d.rdata = st_q.ver;
            default:    st_d.rdata = 32'h0000_0000;
         endcase
      end
      // operand registers are frozen while an eviction runs
      if (AVS_WRITE && st_q.ack && !busy) begin
         case (AVS_ADDRESS)
            OFS_CTRL: begin
               if (AVS_BYTEENABLE[0]) begin
                  st_d.mode64 = AVS_WRITEDATA[CTRL_MODE64];
                  st_d.cpl    = AVS_WRITEDATA[CTRL_CPL +: 2];
                  if (AVS_WRITEDATA[CTRL_START]) begin
                     st_d.fsm     = ST_CHECK;
                     st_d.done    = 1'b0;
                     st_d.gp      = 1'b0;
                     st_d.pf      = 1'b0;
                     st_d.pf_slot = 1'b0;
                  end
               end
            end
            OFS_DESC: st_d.desc = merge(st_q.desc, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            OFS_TGT:  st_d.tgt  = merge(st_q.tgt, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            OFS_SLOT: st_d.slot = merge(st_q.slot, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            OFS_LIN:  st_d.lin  = merge(st_q.lin, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            OFS_ENCL: st_d.encl = merge(st_q.encl, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            OFS_META: st_d.meta = merge(st_q.meta, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            OFS_DEST: st_d.dest = merge(st_q.dest, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            OFS_VER:  st_d.ver  = merge(st_q.ver, AVS_WRITEDATA,
                                        AVS_BYTEENABLE);
            default: ;
         endcase
      end

      // eviction sequence
      case (st_q.fsm)
         ST_IDLE: ;
         // one-cycle priority chain; a fault ends with nothing written
         ST_CHECK: begin
            st_d.fsm = ST_IDLE;
            st_d.done = 1'b1;
            if (st_q.cpl != 2'b00) begin
               st_d.gp = 1'b1;
            end else if (st_q.mode64 ? MAP_INFO.noncanon
                                     : MAP_INFO.seg_fault) begin
               st_d.gp = 1'b1;
            end else if (MAP_INFO.access_fault) begin
               st_d.pf = 1'b1;
            end else if (st_q.desc[ALIGN_DESC-1:0] != '0 ||
                         st_q.tgt[ALIGN_PAGE-1:0] != '0) begin
               st_d.gp = 1'b1;
            end else if (!MAP_INFO.tgt_in_pool) begin
               st_d.pf = 1'b1;
            end else if (st_q.slot[ALIGN_SLOT-1:0] != '0) begin
               st_d.gp = 1'b1;
            end else if (!MAP_INFO.slot_in_pool) begin
               st_d.pf = 1'b1;
               st_d.pf_slot = 1'b1;
            end else if (same_pg) begin
               st_d.gp = 1'b1;
            end else if (st_q.lin != '0 || st_q.encl != '0) begin
               st_d.gp = 1'b1;
            end else if (st_q.meta[ALIGN_META-1:0] != '0 ||
                         st_q.dest[ALIGN_PAGE-1:0] != '0) begin
               st_d.gp = 1'b1;
            end else if (MAP_INFO.conc_busy || MAP_INFO.va_changing) begin
               st_d.gp = 1'b1;
            end else if (MAP_INFO.track_busy || MAP_INFO.consist_fail) begin
               st_d.gp = 1'b1;
            end else if (!MAP_INFO.tgt_valid) begin
               st_d.pf = 1'b1;
            end else if (!MAP_INFO.slot_valid ||
                         MAP_INFO.slot_ptype != PT_VERSION) begin
               st_d.pf = 1'b1;
               st_d.pf_slot = 1'b1;
            end else if (!is_child(MAP_INFO.tgt_ptype) &&
                         MAP_INFO.tgt_ptype != PT_ENCLAVE &&
                         MAP_INFO.tgt_ptype != PT_VERSION) begin
               st_d.pf = 1'b1;
            end else if (is_child(MAP_INFO.tgt_ptype) &&
                         !MAP_INFO.block_ok) begin
               st_d.gp = 1'b1;
            end else begin
               // all fault checks passed
               st_d.flags  = 6'b00_0000;
               st_d.result = RES_OK;
               st_d.done   = 1'b0;
               st_d.fsm    = ST_CRYPT;
               if (is_child(MAP_INFO.tgt_ptype)) begin
                  if (!MAP_INFO.blocked) begin
                     st_d.result = NOT_BLOCKED_CODE;
                     st_d.flags[FL_ZF] = 1'b1;
                     st_d.fsm = ST_IDLE;
                     st_d.done = 1'b1;
                  end else if (!MAP_INFO.track_ok) begin
                     st_d.result = NOT_TRACKED_CODE;
                     st_d.flags[FL_ZF] = 1'b1;
                     st_d.fsm = ST_IDLE;
                     st_d.done = 1'b1;
                  end else begin
                     st_d.o.hdr_eid  = MAP_INFO.owner_eid;
                     st_d.o.meta_eid = MAP_INFO.owner_eid;
                  end
               end else if (MAP_INFO.tgt_ptype == PT_ENCLAVE) begin
                  if (MAP_INFO.child_present) begin
                     st_d.result = CHILD_PRESENT_CODE;
                     st_d.flags[FL_ZF] = 1'b1;
                     st_d.fsm = ST_IDLE;
                     st_d.done = 1'b1;
                  end else begin
                     st_d.o.hdr_eid  = EID_NONE;
                     st_d.o.meta_eid = MAP_INFO.own_eid;
                  end
               end else begin
                  st_d.o.hdr_eid  = EID_NONE;
                  st_d.o.meta_eid = EID_NONE;
               end
               // header starts cleared apart from these fields
               st_d.o.hdr_lin      = MAP_INFO.linear_addr_field;
               st_d.o.hdr_ptype    = MAP_INFO.tgt_ptype;
               st_d.o.hdr_perm     = MAP_INFO.perm;
               st_d.o.hdr_pending  = MAP_INFO.pending;
               st_d.o.hdr_modified = MAP_INFO.modified;
               st_d.o.hdr_pr       = MAP_INFO.perm_restrict_bit;
               st_d.o.counter      = {st_q.ver, 32'h0000_0000};
               st_d.o.dest_ptr     = st_q.dest;
               st_d.o.meta_ptr     = st_q.meta;
               st_d.o.desc_addr    = st_q.desc;
               st_d.o.slot_addr    = st_q.slot;
               st_d.o.map_addr     = st_q.tgt;
               st_d.o.slot_val     = {32'h0000_0000, st_q.ver};
               // request rises only when eviction really proceeds
               st_d.o.crypt_req    = (st_d.fsm == ST_CRYPT);
            end
         end
         // hold request until the engine reports ciphertext and tag out
         ST_CRYPT: begin
            if (CRYPT_DONE) begin
               st_d.o.crypt_req = 1'b0;
               st_d.fsm = ST_WRITE;
            end
         end
         // metadata flags, identifier, zeroed fields; descriptor address
         ST_WRITE: begin
            st_d.o.meta_we = 1'b1;
            st_d.o.desc_we = 1'b1;
            st_d.fsm = ST_SLOT;
         end
         // slot write and map invalidate go out together, in order
         ST_SLOT: begin
            if (MAP_INFO.slot_used) begin
               st_d.result = SLOT_OCCUPIED_CODE;
               st_d.flags[FL_CF] = 1'b1;
            end
            st_d.o.slot_we = 1'b1;
            st_d.o.map_inv = 1'b1;
            st_d.done = 1'b1;
            st_d.fsm = ST_IDLE;
         end
         default: st_d.fsm = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

// ===== evp_evict_assertions.sv
// port-level assertions for the page eviction sequencer
`timescale 1ns/1ps
module evp_evict_assertions
   import evp_pkg::*;
(
   // clock and reset
   input wire logic              MCLK,
   input wire logic              RST_B,
   // register bus handshake
   input wire logic              AVS_READ,
   input wire logic              AVS_WRITE,
   input wire logic              AVS_WAITREQUEST,
   // page map facts and crypto side
   input wire evp_pkg::evp_map_t MAP_INFO,
   input wire logic              CRYPT_DONE,
   input wire evp_pkg::evp_out_t EVICT_OUT
);
   // ------------------------------------------------------------
   // properties, all in the one clock domain
   // ------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   // one wait cycle; writes one cycle after the crypto exit
   a_bus_one_wait: assert property (
      (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
      else $error("bus wait not one cycle");
   a_done_to_write: assert property (
      EVICT_OUT.crypt_req && CRYPT_DONE |=> !EVICT_OUT.crypt_req
      ##1 (EVICT_OUT.meta_we && EVICT_OUT.desc_we))
      else $error("writes late after crypto");
   a_write_after_crypt: assert property (
      EVICT_OUT.meta_we |-> $past(CRYPT_DONE, 2)
      && $past(EVICT_OUT.crypt_req, 2))
      else $error("meta write without crypto");
   a_slot_then_free: assert property (
      EVICT_OUT.meta_we |=> EVICT_OUT.slot_we && EVICT_OUT.map_inv)
      else $error("slot or map strobe missing");
   // counter low word, slot value against the counter, header against the page map
   a_counter_shift: assert property (
      EVICT_OUT.crypt_req |-> EVICT_OUT.counter[31:0] == 32'h0000_0000)
      else $error("counter low word not zero");
   a_slot_version: assert property (
      EVICT_OUT.slot_we |-> EVICT_OUT.slot_val
      == {32'h0000_0000, EVICT_OUT.counter[63:32]})
      else $error("slot value wrong");
   a_hdr_fields: assert property (
      $rose(EVICT_OUT.crypt_req) |->
      EVICT_OUT.hdr_lin == $past(MAP_INFO.linear_addr_field)
      && EVICT_OUT.hdr_perm == $past(MAP_INFO.perm)
      && EVICT_OUT.hdr_ptype == $past(MAP_INFO.tgt_ptype))
      else $error("header fields wrong");
   // identifier binding per page type
   a_child_eid: assert property (
      $rose(EVICT_OUT.crypt_req) && EVICT_OUT.hdr_ptype inside
      {PT_REGULAR, PT_THREAD, PT_TRIMMED} |->
      EVICT_OUT.hdr_eid == $past(MAP_INFO.owner_eid)
      && EVICT_OUT.meta_eid == $past(MAP_INFO.owner_eid))
      else $error("child id wrong");
   a_encl_eid: assert property (
      $rose(EVICT_OUT.crypt_req) && EVICT_OUT.hdr_ptype == PT_ENCLAVE
      |-> EVICT_OUT.hdr_eid == EID_NONE
      && EVICT_OUT.meta_eid == $past(MAP_INFO.own_eid))
      else $error("control id wrong");
   a_version_eid: assert property (
      EVICT_OUT.crypt_req && EVICT_OUT.hdr_ptype == PT_VERSION |->
      EVICT_OUT.hdr_eid == EID_NONE && EVICT_OUT.meta_eid == EID_NONE)
      else $error("version id not zero");

   // main scenarios reached
   c_evicted: cover property (EVICT_OUT.slot_we);
   c_encl: cover property (EVICT_OUT.crypt_req
      && EVICT_OUT.hdr_ptype == PT_ENCLAVE);
   c_version: cover property (EVICT_OUT.crypt_req
      && EVICT_OUT.hdr_ptype == PT_VERSION);
endmodule

// ===== evp_crypt_model.sv
// crypto engine model answering the sequencer after a chosen latency
`timescale 1ns/1ps
module evp_crypt_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // request and latency chosen by the bench
   input  wire logic       crypt_req,
   input  wire logic [3:0] dly,
   // one-cycle completion strobe
   output logic            crypt_done
);
   logic [3:0] cnt_q;

   // registered strobe: never answers in the cycle the request rises
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         crypt_done <= 1'b0;
      end else begin
         crypt_done <= crypt_req && !crypt_done && cnt_q == dly;
         cnt_q <= (crypt_req && !crypt_done) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule

// ===== evp_evict_test.sv
// self-checking testbench for the page eviction sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      checks_done++; \
      if ((got) !== (ex)) begin \
         error_cnt++; \
         $display("[ERR] %s exp %h got %h", nm, ex, got); \
      end \
   end
module evp_evict_test;
   import evp_pkg::*;
   logic        mclk, rst_b, avs_read, avs_write, avs_waitrequest;
   logic [7:0]  avs_address;
   logic [3:0]  avs_byteenable, dly;
   logic [31:0] avs_writedata, avs_readdata, res_m;
   evp_map_t    map_info, cm;
   evp_out_t    evict_out, at_meta, at_slot;
   logic        crypt_done, m64, ev, zf_m, cf_m;
   logic [1:0]  cpl;
   logic [10:0] st_m;
   logic [63:0] eid_m;
   logic [31:0] opv [8]; // desc tgt slot lin encl meta dest version
   int          error_cnt, checks_done, seed, n_meta, n_slot;

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   evp_evict evp_evict_inst (.MCLK(mclk), .RST_B(rst_b),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(avs_waitrequest), .MAP_INFO(map_info),
      .CRYPT_DONE(crypt_done), .EVICT_OUT(evict_out));
   evp_crypt_model evp_crypt_model_inst (.clk(mclk), .rst_n(rst_b),
      .crypt_req(evict_out.crypt_req), .dly(dly),
      .crypt_done(crypt_done));

   // capture the side effects mid-cycle, away from the launching edge
   always @(negedge mclk) begin
      if (evict_out.meta_we === 1'b1) begin
         n_meta++;
         at_meta = evict_out;
      end
      if (evict_out.slot_we === 1'b1) begin
         n_slot++;
         at_slot = evict_out;
      end
   end

   // one bus cycle, held until the edge where waitrequest stands low
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      logic w;
      int n;
      n = 0;
      @(posedge mclk);
      {avs_address, avs_writedata} <= {a, d};
      {avs_write, avs_read} <= {wr, !wr};
      do begin
         @(negedge mclk);
         {w, q} = {avs_waitrequest, avs_readdata};
         @(posedge mclk);
         n++;
      end while (w !== 1'b0 && n < 20);
      if (n >= 20) error_cnt++;
      {avs_write, avs_read} <= 2'b00;
   endtask

   // random operands that pass every check
   task automatic base();
      cm = '0;
      {cm.tgt_in_pool, cm.slot_in_pool, cm.tgt_valid} = 3'h7;
      {cm.slot_valid, cm.block_ok, cm.blocked, cm.track_ok} = 4'hF;
      cm.slot_ptype = PT_VERSION;
      {cm.perm, cm.pending, cm.modified, cm.perm_restrict_bit} =
         6'($random(seed));
      cm.linear_addr_field = $random(seed);
      cm.owner_eid = {$random(seed), $random(seed)};
      cm.own_eid = {$random(seed), $random(seed)};
      opv[0] = $random(seed) & 32'hFFFF_FFE0;
      opv[1] = $random(seed) & 32'hFFFF_F000;
      opv[2] = (opv[1] ^ 32'h0000_1000) | ($random(seed) & 32'h0000_0FF8);
      opv[3] = 32'h0000_0000;
      opv[4] = 32'h0000_0000;
      opv[5] = $random(seed) & 32'hFFFF_FF80;
      opv[6] = $random(seed) & 32'hFFFF_F000;
      opv[7] = $random(seed);
      cpl = 2'h0;
      m64 = 1'($random(seed));
   endtask

   // break one condition of the sequence, or pick another target page type
   task automatic apply(input int k);
      case (k)
         1: cpl = 2'h1;
         2: cm.seg_fault = 1'b1;
         3: cm.noncanon = 1'b1;
         4: cm.access_fault = 1'b1;
         5: opv[0][4] = 1'b1;
         6: opv[1][11] = 1'b1;
         7: cm.tgt_in_pool = 1'b0;
         8: opv[2][2] = 1'b1;
         9: cm.slot_in_pool = 1'b0;
         10: opv[2] = opv[1] | 32'h0000_0008;
         11: opv[3] = 32'h0000_1000;
         12: opv[4] = 32'h0000_0040;
         13: opv[5][6] = 1'b1;
         14: opv[6][11] = 1'b1;
         15: cm.conc_busy = 1'b1;
         16: cm.va_changing = 1'b1;
         17: cm.track_busy = 1'b1;
         18: cm.consist_fail = 1'b1;
         19: cm.tgt_valid = 1'b0;
         20: cm.slot_valid = 1'b0;
         21: cm.slot_ptype = PT_TRIMMED;
         22: cm.block_ok = 1'b0;
         23: cm.blocked = 1'b0;
         24: cm.track_ok = 1'b0;
         25: cm.tgt_ptype = PT_ENCLAVE;
         26: {cm.tgt_ptype, cm.child_present} = {PT_ENCLAVE, 1'b1};
         27: cm.tgt_ptype = PT_VERSION;
         28: cm.tgt_ptype = PT_THREAD;
         29: cm.tgt_ptype = PT_TRIMMED;
         30: cm.slot_used = 1'b1;
         default: ;
      endcase
   endtask

   // reference: checks in order, flags and result kept on a fault
   task automatic model();
      logic ch;
      ch = cm.tgt_ptype inside {PT_REGULAR, PT_THREAD, PT_TRIMMED};
      ev = 1'b0;
      st_m = 11'h002;
      if (cpl != 2'h0) st_m[2] = 1'b1;
      else if (m64 ? cm.noncanon : cm.seg_fault) st_m[2] = 1'b1;
      else if (cm.access_fault) st_m[3] = 1'b1;
      else if (opv[0][4:0] != 0 || opv[1][11:0] != 0) st_m[2] = 1'b1;
      else if (!cm.tgt_in_pool) st_m[3] = 1'b1;
      else if (opv[2][2:0] != 0) st_m[2] = 1'b1;
      else if (!cm.slot_in_pool) st_m[4:3] = 2'h3;
      else if (opv[1][31:12] == opv[2][31:12]) st_m[2] = 1'b1;
      else if (opv[3] != 0 || opv[4] != 0) st_m[2] = 1'b1;
      else if (opv[5][6:0] != 0 || opv[6][11:0] != 0) st_m[2] = 1'b1;
      else if (cm.conc_busy || cm.va_changing) st_m[2] = 1'b1;
      else if (cm.track_busy || cm.consist_fail) st_m[2] = 1'b1;
      else if (!cm.tgt_valid) st_m[3] = 1'b1;
      else if (!cm.slot_valid || cm.slot_ptype != PT_VERSION)
         st_m[4:3] = 2'h3;
      else if (ch && !cm.block_ok) st_m[2] = 1'b1;
      else begin
         {res_m, zf_m, cf_m} = {RES_OK, 2'h0};
         if (ch && !cm.blocked) {res_m, zf_m} = {NOT_BLOCKED_CODE, 1'b1};
         else if (ch && !cm.track_ok)
            {res_m, zf_m} = {NOT_TRACKED_CODE, 1'b1};
         else if (cm.tgt_ptype == PT_ENCLAVE && cm.child_present)
            {res_m, zf_m} = {CHILD_PRESENT_CODE, 1'b1};
         else begin
            ev = 1'b1;
            if (cm.slot_used) {res_m, cf_m} = {SLOT_OCCUPIED_CODE, 1'b1};
         end
      end
      st_m[10:9] = {zf_m, cf_m};
      eid_m = ch ? cm.owner_eid :
         (cm.tgt_ptype == PT_ENCLAVE ? cm.own_eid : EID_NONE);
   endtask

   // program operands, start, wait for done and compare
   task automatic run(input int k);
      logic [31:0] st, r;
      int n;
      model();
      {n_meta, n_slot} = '0;
      @(posedge mclk);
      map_info <= cm;
      dly <= 4'({$random(seed)} % 10);
      for (int i = 0; i < 8; i++) xfer(1'b1, OFS_DESC + 8'(4 * i), opv[i], r);
      xfer(1'b1, OFS_CTRL, {28'h000_0000, cpl, m64, 1'b1}, r);
      if (ev && dly >= 6) begin
         xfer(1'b1, OFS_VER, ~opv[7], r);
         xfer(1'b1, OFS_CTRL, {28'h000_0000, cpl, m64, 1'b1}, r);
      end
      n = 0;
      do begin
         xfer(1'b0, OFS_STATUS, 32'h0000_0000, st);
         n++;
      end while (st[1:0] !== 2'h2 && n < 60);
      xfer(1'b0, OFS_RESULT, 32'h0000_0000, r);
      `CHK("status", st_m, st[10:0])
      `CHK("result", res_m, r)
      `CHK("meta writes", int'(ev), n_meta)
      `CHK("slot writes", int'(ev), n_slot)
      if (ev) begin
         `CHK("counter", {opv[7], 32'h0000_0000}, at_meta.counter)
         `CHK("dest ptr", opv[6], at_meta.dest_ptr)
         `CHK("meta eid", eid_m, at_meta.meta_eid)
         `CHK("slot value", {32'h0000_0000, opv[7]}, at_slot.slot_val)
         `CHK("map addr", opv[1], at_slot.map_addr)
      end
      $display("test %0d done", k);
   endtask

   task automatic end_sim();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // each condition alone, then random pairs to probe check order
   initial begin
      logic [31:0] r;
      {seed, error_cnt, checks_done} = {32'd31, 64'd0};
      {rst_b, avs_read, avs_write, avs_address, avs_writedata} = '0;
      {map_info, dly, res_m, zf_m, cf_m} = '0;
      avs_byteenable = 4'hF;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      xfer(1'b1, 8'hFC, 32'hFFFF_FFFF, r);
      xfer(1'b0, 8'hFC, 32'h0000_0000, r);
      `CHK("unmapped", 32'h0000_0000, r)
      for (int k = 0; k < 31; k++) begin
         base();
         apply(k);
         run(k);
      end
      for (int j = 0; j < 40; j++) begin
         base();
         apply({$random(seed)} % 31);
         apply({$random(seed)} % 31);
         run(100 + j);
      end
      end_sim();
   end

   // hang guard
   initial begin
      repeat (30000) @(posedge mclk);
      error_cnt++;
      end_sim();
   end
endmodule
bind evp_evict evp_evict_assertions evp_evict_assertions_inst (.*);
